//--- saaz_pkg.sv
package saaz_pkg;
  // socket register byte offsets
  localparam logic [7:0] OFF_EVENT = 8'h00;
  localparam logic [7:0] OFF_MASK = 8'h04;
  localparam logic [7:0] OFF_PRESENT = 8'h08;
  localparam logic [7:0] OFF_FORCE = 8'h0c;
  localparam logic [7:0] OFF_CONTROL = 8'h10;
  localparam logic [7:0] OFF_RSVD_LO = 8'h14;
  localparam logic [7:0] OFF_RSVD_HI = 8'h1c;
  localparam logic [7:0] OFF_PWR_MGMT = 8'h20;
  // configuration registers; only system and card control are held by this block
  localparam logic [7:0] OFF_SYS_CTRL = 8'h80;
  localparam logic [7:0] OFF_CARD_CTRL = 8'h90;
  localparam logic [7:0] OFF_LINK_CTRL = 8'h40;
  // field positions
  localparam int BIT_VID_EN = 9;
  localparam int BIT_STD_MODEL = 10;
  localparam int BIT_VID_IN_USE = 11;
  localparam int BIT_VID_SUPPORT = 27;
  localparam int BIT_OSC_EN = 27;
  // card control sits in byte 91h, i.e. bits 15:8 of word 90h
  localparam int BIT_SPKR_EN = 9;
  localparam int BIT_PWM_ROUTE = 10;
  localparam int BIT_LEGACY_VID = 14;
  // power management
  localparam logic [1:0] PSTATE_D1 = 2'h1;
  localparam logic [1:0] PSTATE_D2 = 2'h2;
  // activity hold time
  localparam int HOLD_MS = 64;
  localparam int CLK_KHZ = 25000;
  localparam int HOLD_CYCLES = HOLD_MS * CLK_KHZ;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
endpackage

//--- saaz_stretch.sv
`timescale 1ns/1ps
// retriggerable pulse stretcher for one activity output
module saaz_stretch #(
  parameter int HOLD = saaz_pkg::HOLD_CYCLES
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic trigger_in,
  input wire logic force_off_in,
  output logic active_out
);
  logic [31:0] count;

  // restart on every trigger, count down otherwise
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in || force_off_in) begin
      count <= 32'h0;
    end else if (trigger_in) begin
      count <= 32'(HOLD);
    end else if (count != 32'h0) begin
      count <= count - 32'h1;
    end
  end

  // output high on a trigger and while count is above one
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in || force_off_in) begin
      active_out <= 1'b0;
    end else begin
      active_out <= trigger_in || (count > 32'h1);
    end
  end
endmodule

//--- saaz_top.sv
`timescale 1ns/1ps
// Summary of operation
// - standard-model indicator always reads one
// - internal oscillator runs only when enabled
// - pullup for 16-bit, pulldown for cardbus
// - speaker output is xor of audio
// - speaker output gated by enable bit
// - route pwm audio when route bit set on a cardbus card
// - socket 0 pwm wins when both routed
// - per-socket and combined activity outputs
// - activity output held high for 64 ms
// - activity only when inserted, powered, unreset
// - activity sources per card type
// - activity forced off in D1/D2, suspend or clkrun stop
// - new activity restarts the hold counter
// - socket register offset decode
// - in-use flag set when any video enabled
// - force-event bit 27 sets support flag
module saaz_top #(
  parameter int HOLD = saaz_pkg::HOLD_CYCLES
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic reg_sock_in,
  output logic [31:0] reg_rdata_out,
  input wire logic [1:0] card_inserted_in,
  input wire logic [1:0] card_is_cardbus_in,
  input wire logic [1:0] card_powered_in,
  input wire logic [1:0] card_in_reset_in,
  input wire logic [1:0] card16_ready_irq_in,
  input wire logic [1:0] cb_frame_n_in,
  input wire logic [1:0] cb_irdy_n_in,
  input wire logic [1:0] cb_req_n_in,
  input wire logic [1:0] audio_bin_in,
  input wire logic [1:0] audio_pwm_in,
  input wire logic suspend_in,
  input wire logic clkrun_stop_in,
  output logic speaker_out,
  output logic pwm_audio_out,
  output logic activity_led_socket_a,
  output logic activity_led_socket_b,
  output logic activity_led_any,
  output logic internal_osc_enable,
  output logic [1:0] stschg_pullup_out,
  output logic [1:0] stschg_pulldown_out,
  output logic [1:0] video_port_enable_out
);
  logic [31:0] sys_ctrl;
  logic [31:0] card_ctrl [2];
  logic [31:0] event_mask [2];
  logic [31:0] pwr_mgmt [2];
  logic [1:0] video_port_supported;
  logic [1:0] video_port_enable;
  logic video_port_in_use;
  logic [1:0] act_trig;
  logic [1:0] act_led;
  logic [1:0] dstate [2];
  logic force_off;
  logic sel;
  logic [31:0] next_rdata;

  assign sel = reg_sock_in;

  // socket-indexed writable registers
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < 2; i++) begin
        card_ctrl[i] <= saaz_pkg::RESET_WORD;
        event_mask[i] <= saaz_pkg::RESET_WORD;
        pwr_mgmt[i] <= saaz_pkg::RESET_WORD;
      end
    end else if (reg_wr_in) begin
      unique case (reg_addr_in)
        saaz_pkg::OFF_CARD_CTRL: card_ctrl[sel] <= reg_wdata_in;
        saaz_pkg::OFF_MASK: event_mask[sel] <= reg_wdata_in;
        saaz_pkg::OFF_PWR_MGMT: pwr_mgmt[sel] <= reg_wdata_in;
        default: ;
      endcase
    end
  end

  // system control, shared by both functions
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      sys_ctrl <= saaz_pkg::RESET_WORD;
    end else if (reg_wr_in && reg_addr_in == saaz_pkg::OFF_SYS_CTRL) begin
      sys_ctrl <= reg_wdata_in;
    end
  end

  // support flags set through force-event, video enables via control
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      video_port_supported <= 2'h0;
      video_port_enable <= 2'h0;
    end else if (reg_wr_in) begin
      if (reg_addr_in == saaz_pkg::OFF_FORCE && reg_wdata_in[saaz_pkg::BIT_VID_SUPPORT]) begin
        video_port_supported[sel] <= 1'b1;
      end
      if (reg_addr_in == saaz_pkg::OFF_CONTROL) begin
        video_port_enable[sel] <= reg_wdata_in[saaz_pkg::BIT_VID_EN];
      end
    end
  end

  // legacy card-control bit or new-model bit sets the video in-use flag
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      dstate[i] = pwr_mgmt[i][1:0];
    end
    video_port_in_use = |(video_port_enable | {card_ctrl[1][saaz_pkg::BIT_LEGACY_VID],
                                               card_ctrl[0][saaz_pkg::BIT_LEGACY_VID]});
    force_off = suspend_in || clkrun_stop_in
      || dstate[0] == saaz_pkg::PSTATE_D1 || dstate[0] == saaz_pkg::PSTATE_D2
      || dstate[1] == saaz_pkg::PSTATE_D1 || dstate[1] == saaz_pkg::PSTATE_D2;
  end

  // read mux
  always_comb begin
    next_rdata = 32'h0;
    unique case (reg_addr_in)
      saaz_pkg::OFF_EVENT: next_rdata = 32'h0;
      saaz_pkg::OFF_MASK: next_rdata = event_mask[sel];
      saaz_pkg::OFF_PRESENT: begin
        next_rdata[saaz_pkg::BIT_VID_SUPPORT] = video_port_supported[sel];
        next_rdata[0] = card_inserted_in[sel];
      end
      saaz_pkg::OFF_CONTROL: begin
        next_rdata[saaz_pkg::BIT_VID_EN] = video_port_enable[sel];
        next_rdata[saaz_pkg::BIT_STD_MODEL] = 1'b1;
        next_rdata[saaz_pkg::BIT_VID_IN_USE] = video_port_in_use;
      end
      saaz_pkg::OFF_PWR_MGMT: next_rdata = pwr_mgmt[sel];
      saaz_pkg::OFF_SYS_CTRL: next_rdata = sys_ctrl;
      saaz_pkg::OFF_CARD_CTRL: next_rdata = card_ctrl[sel];
      default: next_rdata = 32'h0; // reserved 14h-1ch and unmapped read zero
    endcase
  end

  // read data valid the cycle after the strobe only
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in || !reg_rd_in) begin
      reg_rdata_out <= 32'h0;
    end else begin
      reg_rdata_out <= next_rdata;
    end
  end

  // activity detect per socket
  for (genvar s = 0; s < 2; s++) begin : g_sock
    always_comb begin
      act_trig[s] = card_inserted_in[s] && card_powered_in[s] && !card_in_reset_in[s]
        && (card_is_cardbus_in[s]
            ? (!cb_frame_n_in[s] || !cb_irdy_n_in[s] || !cb_req_n_in[s])
            : !card16_ready_irq_in[s]);
    end
    saaz_stretch #(.HOLD(HOLD)) u_stretch (
      .core_clk_in(core_clk_in),
      .sys_rst_in(sys_rst_in),
      .trigger_in(act_trig[s]),
      .force_off_in(force_off),
      .active_out(act_led[s])
    );
  end

  // registered activity outputs
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      activity_led_socket_a <= 1'b0;
      activity_led_socket_b <= 1'b0;
      activity_led_any <= 1'b0;
    end else begin
      activity_led_socket_a <= act_led[0];
      activity_led_socket_b <= act_led[1];
      activity_led_any <= |act_led;
    end
  end

  // audio outputs
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      speaker_out <= 1'b0;
      pwm_audio_out <= 1'b0;
    end else begin
      speaker_out <= (audio_bin_in[0] ^ audio_bin_in[1])
        && (card_ctrl[0][saaz_pkg::BIT_SPKR_EN] || card_ctrl[1][saaz_pkg::BIT_SPKR_EN]);
      if (card_ctrl[0][saaz_pkg::BIT_PWM_ROUTE] && card_is_cardbus_in[0]) begin
        pwm_audio_out <= audio_pwm_in[0];
      end else if (card_ctrl[1][saaz_pkg::BIT_PWM_ROUTE] && card_is_cardbus_in[1]) begin
        pwm_audio_out <= audio_pwm_in[1];
      end else begin
        pwm_audio_out <= 1'b0;
      end
    end
  end

  // oscillator enable, status pull selection, video enables
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      internal_osc_enable <= 1'b0;
      stschg_pullup_out <= 2'h0;
      stschg_pulldown_out <= 2'h0;
      video_port_enable_out <= 2'h0;
    end else begin
      internal_osc_enable <= sys_ctrl[saaz_pkg::BIT_OSC_EN];
      stschg_pullup_out <= card_inserted_in & ~card_is_cardbus_in;
      stschg_pulldown_out <= card_inserted_in & card_is_cardbus_in;
      video_port_enable_out <= video_port_enable;
    end
  end
endmodule

//--- saaz_monitor.sv
`timescale 1ns/1ps
// port-level checks for the socket aux block
module saaz_monitor #(
  parameter int HOLD = 20
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic [1:0] card_inserted_in,
  input wire logic [1:0] card_is_cardbus_in,
  input wire logic [1:0] card_powered_in,
  input wire logic [1:0] audio_bin_in,
  input wire logic [1:0] audio_pwm_in,
  input wire logic suspend_in,
  input wire logic clkrun_stop_in,
  input wire logic speaker_out,
  input wire logic pwm_audio_out,
  input wire logic activity_led_socket_a,
  input wire logic activity_led_socket_b,
  input wire logic activity_led_any,
  input wire logic internal_osc_enable,
  input wire logic [1:0] stschg_pullup_out,
  input wire logic [1:0] stschg_pulldown_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  // outputs tied to their causes
  spk_xor_a: assert property (speaker_out |-> $past(^audio_bin_in))
    else $error("speaker high without xor");
  pwm_src_a: assert property (pwm_audio_out |-> $past(|audio_pwm_in))
    else $error("pwm high without source");
  led_any_a: assert property ((activity_led_socket_a || activity_led_socket_b) |-> ##[0:1] activity_led_any)
    else $error("combined led missing");
  force_off_a: assert property ((suspend_in || clkrun_stop_in)[*2] |=> !activity_led_socket_a && !activity_led_socket_b)
    else $error("led not cut off");
  led_cause_a: assert property ($rose(activity_led_socket_a) |-> $past(card_inserted_in[0] && card_powered_in[0]))
    else $error("led without live card");
  led_hold_a: assert property ($rose(activity_led_socket_a) ##1 (!suspend_in && !clkrun_stop_in)[*6] |-> activity_led_socket_a)
    else $error("led dropped early");
  pull_up_a: assert property (stschg_pullup_out[0] |-> $past(card_inserted_in[0] && !card_is_cardbus_in[0]))
    else $error("pullup wrong");
  pull_down_a: assert property (stschg_pulldown_out[1] |-> $past(card_inserted_in[1] && card_is_cardbus_in[1]))
    else $error("pulldown wrong");
  osc_write_a: assert property (!$stable(internal_osc_enable) |-> $past(reg_wr_in) || $past(reg_wr_in, 2))
    else $error("osc changed without write");
  rdata_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
    else $error("read data outside slot");
  // main scenarios reached
  cover property ($rose(activity_led_socket_a));
  cover property (speaker_out);
  cover property (pwm_audio_out);
endmodule

bind saaz_top saaz_monitor #(.HOLD(HOLD)) mon_u (.*);

//--- saaz_card_model.sv
`timescale 1ns/1ps
// card pair: drives bus activity lines while commanded busy
module saaz_card_model (
  input wire logic [1:0] busy_in,
  input wire logic [1:0] cardbus_in,
  output logic [1:0] ready_irq_out,
  output logic [1:0] bus_n_out
);
  // 16-bit card pulls ready low, cardbus card asserts its bus lines
  assign ready_irq_out = ~(busy_in & ~cardbus_in);
  assign bus_n_out = ~(busy_in & cardbus_in);
endmodule

//--- test_socket_activity_audio_zv.sv
`timescale 1ns/1ps
module test_socket_activity_audio_zv;
  localparam int HOLD = 20;
  logic core_clk_in = 1'b0, sys_rst_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0, reg_sock_in = 1'b0;
  logic suspend_in = 1'b0, clkrun_stop_in = 1'b0, speaker_out, pwm_audio_out, internal_osc_enable;
  logic activity_led_socket_a, activity_led_socket_b, activity_led_any;
  logic [7:0] reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out, v;
  logic [1:0] card_inserted_in = 2'h0, card_is_cardbus_in = 2'h0, card_powered_in = 2'h0, card_in_reset_in = 2'h0;
  logic [1:0] audio_bin_in = 2'h0, audio_pwm_in = 2'h0, busy = 2'h0, card16_ready_irq_in, cb_frame_n_in;
  logic [1:0] stschg_pullup_out, stschg_pulldown_out, video_port_enable_out;
  int bad_count = 0, n_checks = 0;
  logic rd_sock = 1'b0;
  saaz_top #(.HOLD(HOLD)) dut_u (.*, .cb_irdy_n_in(cb_frame_n_in), .cb_req_n_in(cb_frame_n_in));
  saaz_card_model card_u (.busy_in(busy), .cardbus_in(card_is_cardbus_in), .ready_irq_out(card16_ready_irq_in),
    .bus_n_out(cb_frame_n_in));
  // clock and watchdog
  initial begin
    forever #20 core_clk_in = ~core_clk_in;
  end
  initial begin
    repeat (5000) @(posedge core_clk_in);
    bad_count++;
    conclude();
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk_in);
    @(negedge core_clk_in);
  endtask
  task automatic wreg(input logic s, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    reg_sock_in <= s;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk_in);
    reg_sock_in <= rd_sock;
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
    @(negedge core_clk_in);
    d = reg_rdata_out;
  endtask
  task automatic act(input logic [1:0] m, input int n);
    @(posedge core_clk_in);
    busy <= m;
    @(posedge core_clk_in);
    busy <= 2'h0;
    settle(n);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    rreg(8'h10, v);
    chk("ctrl", v, 32'h400);
    rreg(8'h14, v);
    chk("rsvd", v, 32'h0);
    rreg(8'h60, v);
    chk("unmapped", v, 32'h0);
    rreg(8'h08, v);
    chk("no_support", v[27], 1'b0);
    wreg(1'b0, 8'h0c, 32'h0800_0000);
    rreg(8'h08, v);
    chk("support", v[27], 1'b1);
    rd_sock = 1'b1;
    rreg(8'h08, v);
    chk("other_sock", v[27], 1'b0);
    rd_sock = 1'b0;
    wreg(1'b0, 8'h10, 32'h0000_0200);
    rreg(8'h10, v);
    chk("in_use", v[11:9], 3'h7);
    rd_sock = 1'b1;
    rreg(8'h10, v);
    chk("busy_other", v[11:9], 3'h6);
    rd_sock = 1'b0;
    chk("vid_en", video_port_enable_out, 2'h1);
    chk("osc_off", internal_osc_enable, 1'b0);
    wreg(1'b0, 8'h80, 32'h0800_0000);
    settle(2);
    chk("osc_on", internal_osc_enable, 1'b1);
    $display("registers done");
    @(posedge core_clk_in);
    card_inserted_in <= 2'h3;
    card_powered_in <= 2'h3;
    card_is_cardbus_in <= 2'h2;
    audio_bin_in <= 2'h1;
    settle(3);
    chk("pull", {stschg_pulldown_out, stschg_pullup_out}, 4'h9);
    chk("spk_off", speaker_out, 1'b0);
    wreg(1'b0, 8'h90, 32'h200);
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk_in);
      audio_bin_in <= i[1:0];
      settle(2);
      chk("spk", speaker_out, ^i[1:0]);
    end
    @(posedge core_clk_in);
    card_is_cardbus_in <= 2'h3;
    audio_pwm_in <= 2'h2;
    wreg(1'b1, 8'h90, 32'h400);
    settle(2);
    chk("pwm_b", pwm_audio_out, 1'b1);
    wreg(1'b0, 8'h90, 32'h600);
    settle(2);
    chk("pwm_both", pwm_audio_out, 1'b0);
    @(posedge core_clk_in);
    audio_pwm_in <= 2'h1;
    settle(2);
    chk("pwm_a", pwm_audio_out, 1'b1);
    @(posedge core_clk_in);
    card_is_cardbus_in <= 2'h2;
    $display("audio done");
    act(2'h1, HOLD - 4);
    chk("led_a", {activity_led_any, activity_led_socket_b, activity_led_socket_a}, 3'h5);
    act(2'h1, HOLD - 4);
    chk("led_retrig", activity_led_socket_a, 1'b1);
    settle(8);
    chk("led_end", activity_led_socket_a, 1'b0);
    for (int k = 1; k < 3; k++) begin
      act(2'h2, 3);
      chk("led_b", activity_led_socket_b, 1'b1);
      @(posedge core_clk_in);
      {clkrun_stop_in, suspend_in} <= k[1:0];
      settle(3);
      chk("led_cut", activity_led_socket_b, 1'b0);
      @(posedge core_clk_in);
      {clkrun_stop_in, suspend_in} <= 2'h0;
      settle(HOLD + 4);
    end
    wreg(1'b0, 8'h20, 32'h1);
    act(2'h1, 3);
    chk("led_d1", activity_led_socket_a, 1'b0);
    wreg(1'b0, 8'h20, 32'h0);
    @(posedge core_clk_in);
    card_powered_in <= 2'h2;
    act(2'h1, 3);
    chk("led_unpowered", activity_led_socket_a, 1'b0);
    $display("activity done");
    conclude();
  end
endmodule
